/* design/multi_function_pin_freq_control.sv */
// Frequency profile switching, power-save, timer and pin function control
//
// Summary of operation
// RULE1 - Four stored feedback divider profiles give four selectable VCO frequencies.
// RULE2 - Every VCO change goes through the overshoot limiter, never a free jump.
// RULE3 - Profile change moves the VCO smoothly up or down to the selected target.
// RULE4 - Selection: disabled gives 0, pin mode, serial pins, or register field.
// RULE5 - Software must not pick pin 3 switching without pin 1 switching.
// RULE6 - A two-bit field picks which profile programming writes target.
// RULE7 - Profile data writes are stored into the slot that field picks.
// RULE8 - Power-save mode moves output one to 32kHz while the end device sleeps.
// RULE9 - Pin function fields reset to the plain output-enable function.
// RULE10 - Software writes code 10 to choose power-save for a pin.
// RULE11 - Timer delays of 0.5, 1, 2 and 4 seconds by a two-bit field.
// RULE12 - Expiry sets a timeout flag; writing timer enable 0 clears it.
// RULE13 - On expiry with reset control on, drive a 250ms reset pulse.
// RULE14 - On expiry with switching on, active profile returns to profile zero.
// RULE15 - After the reset pulse, the switching function is disabled.
// RULE16 - Pin one: output enable, power-down, power-save, select bit, or reset out.
// RULE17 - Output-enable mode gates only single-ended output one.
// RULE18 - Power-down low stops all outputs except an enabled 32kHz output.
// RULE19 - The other outputs run only with power-down high, global and own enable set; the 32kHz output needs only its own enable.
// RULE20 - Two independent four-bit crystal trims in 1, 2, 4, 8 pF steps.
// RULE21 - Software computes trim code as twice load capacitance minus 7pF.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
module multi_function_pin_freq_control #(
  parameter int TIMER_BASE_CYCLES = freq_ctrl_pkg::TIMER_BASE_CYCLES,
  parameter int RESET_PULSE_CYCLES = freq_ctrl_pkg::RESET_PULSE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic control_pin_one_in,
  output logic control_pin_one_out,
  output logic control_pin_one_oe,
  input wire logic control_pin_three,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  output logic [freq_ctrl_pkg::DIV_W-1:0] vco_divider,
  output logic [1:0] active_profile,
  output logic single_ended_out1_run,
  output logic out1_use_32k,
  output logic diff1_run,
  output logic diff2_run,
  output logic clk32k_run,
  output logic chip_power_down,
  output logic [3:0] xin_trim,
  output logic [3:0] xout_trim
);
  localparam int TW = freq_ctrl_pkg::TIMER_W;
  localparam int DW = freq_ctrl_pkg::DIV_W;
  typedef enum logic [1:0] {T_IDLE, T_RUN, T_DONE} timer_state_t;

  logic [7:0] func_sel;
  logic [7:0] timer_ctrl;
  logic [7:0] out_ctrl;
  logic [7:0] xtal_trim;
  logic [1:0] prog_sel;
  logic [DW-1:0] profile [freq_ctrl_pkg::PROFILES];
  logic [3:0] pins;
  logic pin1;
  logic pin3;
  logic [1:0] serial_sel;
  logic [1:0] pin1_fn;
  logic [1:0] pin3_fn;
  logic [1:0] next_profile;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  timer_state_t timer_state;
  logic [TW-1:0] timer_count;
  logic [TW-1:0] timer_limit;
  logic expire;
  logic timeout_flag;
  logic [TW-1:0] pulse_count;
  logic pulse_active;
  logic pulse_last;
  logic power_down_n;
  logic stepping;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= freq_ctrl_pkg::VCO_NOW_OFS;
  endfunction

  pin_sync3 #(.W(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({control_pin_one_in, control_pin_three, serial_clock_pin, serial_data_pin}),
    .level(pins)
  );
  assign pin1 = pins[3];
  assign pin3 = pins[2];
  assign serial_sel = pins[1:0];
  assign pin1_fn = func_sel[freq_ctrl_pkg::PIN1_FS_LSB +: 2];
  assign pin3_fn = func_sel[freq_ctrl_pkg::PIN3_FS_LSB +: 2];

  // AXI4-Lite write: address and data may arrive in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= freq_ctrl_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? freq_ctrl_pkg::RESP_OKAY : freq_ctrl_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // Control registers; function fields reset to output enable [RULE9]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      func_sel <= freq_ctrl_pkg::FUNC_SEL_RESET;
      timer_ctrl <= freq_ctrl_pkg::TIMER_CTRL_RESET;
      out_ctrl <= freq_ctrl_pkg::OUT_CTRL_RESET;
      xtal_trim <= freq_ctrl_pkg::XTAL_TRIM_RESET;
      prog_sel <= freq_ctrl_pkg::PROG_SEL_RESET;
    end
    else
    begin
      if (do_write && aw_addr == freq_ctrl_pkg::FUNC_SEL_OFS && w_strb[0])
        func_sel <= w_data[7:0];
      if (do_write && aw_addr == freq_ctrl_pkg::TIMER_CTRL_OFS && w_strb[0])
        timer_ctrl <= w_data[7:0];
      // Hardware disable after the pulse overrides a same-cycle write
      if (pulse_last)
        timer_ctrl[freq_ctrl_pkg::SWITCH_EN_BIT] <= 1'b0; // [RULE15]
      if (do_write && aw_addr == freq_ctrl_pkg::OUT_CTRL_OFS && w_strb[0])
        out_ctrl <= w_data[7:0];
      if (do_write && aw_addr == freq_ctrl_pkg::XTAL_TRIM_OFS && w_strb[0])
        xtal_trim <= w_data[7:0]; // [RULE20]
      if (do_write && aw_addr == freq_ctrl_pkg::PROG_SEL_OFS && w_strb[0])
        prog_sel <= w_data[freq_ctrl_pkg::PROG_LSB +: 2]; // [RULE6]
    end
  end

  // Profile store, one slot per target frequency [RULE1]
  for (genvar g = 0; g < freq_ctrl_pkg::PROFILES; g++)
  begin : g_profile
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        profile[g] <= freq_ctrl_pkg::PROFILE_RESET;
      else if (do_write && aw_addr == freq_ctrl_pkg::PROFILE_DATA_OFS && prog_sel == 2'(g))
        profile[g] <= DW'(merge(32'(profile[g]), w_data, w_strb)); // [RULE7]
    end
  end

  // AXI4-Lite read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= freq_ctrl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? freq_ctrl_pkg::RESP_OKAY : freq_ctrl_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        freq_ctrl_pkg::FUNC_SEL_OFS: s_axi_rdata <= {24'h000000, func_sel};
        freq_ctrl_pkg::TIMER_CTRL_OFS: s_axi_rdata <= {24'h000000, timer_ctrl};
        freq_ctrl_pkg::OUT_CTRL_OFS: s_axi_rdata <= {24'h000000, out_ctrl};
        freq_ctrl_pkg::PROG_SEL_OFS: s_axi_rdata <= {28'h0000000, prog_sel, 2'h0};
        freq_ctrl_pkg::PROFILE_DATA_OFS: s_axi_rdata <= 32'(profile[prog_sel]);
        freq_ctrl_pkg::XTAL_TRIM_OFS: s_axi_rdata <= {24'h000000, xtal_trim};
        freq_ctrl_pkg::STATUS_OFS:
          s_axi_rdata <= {26'h0000000, out1_use_32k, pulse_active, stepping, active_profile, timeout_flag};
        freq_ctrl_pkg::VCO_NOW_OFS: s_axi_rdata <= 32'(vco_divider);
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Selection priority; pin-3-only switching is unsupported and falls to zero [RULE4] [RULE5] [RULE14]
  always_comb
  begin
    if (!timer_ctrl[freq_ctrl_pkg::SWITCH_EN_BIT] || timeout_flag)
      next_profile = 2'h0;
    else if (pin1_fn == freq_ctrl_pkg::FN_SWITCH && pin3_fn == freq_ctrl_pkg::FN_SWITCH)
      next_profile = {pin3, pin1};
    else if (pin1_fn == freq_ctrl_pkg::FN_SWITCH)
      next_profile = {1'b0, pin1};
    else if (pin3_fn == freq_ctrl_pkg::FN_SWITCH)
      next_profile = 2'h0;
    else if (!func_sel[freq_ctrl_pkg::SER_SEL_BIT])
      next_profile = serial_sel;
    else
      next_profile = func_sel[freq_ctrl_pkg::REG_PROF_LSB +: 2];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_profile <= 2'h0;
    else
      active_profile <= next_profile;
  end

  vco_step_limiter u_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .target(profile[active_profile]),
    .current(vco_divider),
    .busy(stepping)
  );

  // Timeout timer, one shot until the enable is written low [RULE11]
  assign timer_limit = TW'(TIMER_BASE_CYCLES) << timer_ctrl[freq_ctrl_pkg::TSEL_LSB +: 2];
  assign expire = (timer_state == T_RUN) && (timer_count == timer_limit - 1'b1);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !timer_ctrl[freq_ctrl_pkg::TIMER_EN_BIT])
    begin
      timer_state <= T_IDLE;
      timer_count <= '0;
    end
    else
    begin
      case (timer_state)
        T_IDLE: timer_state <= T_RUN;
        T_RUN:
        begin
          timer_count <= timer_count + 1'b1;
          if (expire)
            timer_state <= T_DONE;
        end
        T_DONE: timer_state <= T_DONE;
        default: timer_state <= T_IDLE;
      endcase
    end
  end

  // Expiry wins over a clear in the same cycle [RULE12]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timeout_flag <= 1'b0;
    else if (expire)
      timeout_flag <= 1'b1;
    else if (!timer_ctrl[freq_ctrl_pkg::TIMER_EN_BIT])
      timeout_flag <= 1'b0;
  end

  // Reset pulse, driven active low on pin one when selected [RULE13] [RULE16]
  assign pulse_active = (pulse_count != '0);
  assign pulse_last = (pulse_count == TW'(1));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pulse_count <= '0;
    else if (expire && timer_ctrl[freq_ctrl_pkg::RST_CTRL_BIT])
      pulse_count <= TW'(RESET_PULSE_CYCLES);
    else if (pulse_active)
      pulse_count <= pulse_count - 1'b1;
  end
  assign control_pin_one_oe = timer_ctrl[freq_ctrl_pkg::PIN1_RST_OUT_BIT];
  assign control_pin_one_out = !pulse_active;

  // Output gating [RULE16] [RULE17] [RULE18] [RULE19]
  assign power_down_n = !(pin1_fn == freq_ctrl_pkg::FN_POWER_DOWN && !pin1 && !control_pin_one_oe);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      single_ended_out1_run <= 1'b0;
      out1_use_32k <= 1'b0;
      diff1_run <= 1'b0;
      diff2_run <= 1'b0;
      clk32k_run <= 1'b0;
      chip_power_down <= 1'b0;
      xin_trim <= 4'h0;
      xout_trim <= 4'h0;
    end
    else
    begin
      single_ended_out1_run <= power_down_n && out_ctrl[freq_ctrl_pkg::OE_EN_BIT] &&
        out_ctrl[freq_ctrl_pkg::OUT1_EN_BIT] && !(pin1_fn == freq_ctrl_pkg::FN_OUT_ENABLE && !pin1);
      out1_use_32k <= pin1_fn == freq_ctrl_pkg::FN_POWER_SAVE && !pin1; // [RULE8] [RULE10]
      diff1_run <= power_down_n && out_ctrl[freq_ctrl_pkg::OE_EN_BIT] && out_ctrl[freq_ctrl_pkg::DIFF1_EN_BIT];
      diff2_run <= power_down_n && out_ctrl[freq_ctrl_pkg::OE_EN_BIT] && out_ctrl[freq_ctrl_pkg::DIFF2_EN_BIT];
      // The 32kHz clock free-runs through power-down
      clk32k_run <= out_ctrl[freq_ctrl_pkg::CLK32_EN_BIT];
      chip_power_down <= !power_down_n;
      xin_trim <= xtal_trim[3:0]; // [RULE20]
      xout_trim <= xtal_trim[freq_ctrl_pkg::XOUT_LSB +: 4];
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_expire_armed;
    expire && timer_ctrl[freq_ctrl_pkg::RST_CTRL_BIT];
  endsequence
  sequence s_pulse_started;
    pulse_active && pulse_count == TW'(RESET_PULSE_CYCLES);
  endsequence

  a_select_disabled: assert property (!timer_ctrl[freq_ctrl_pkg::SWITCH_EN_BIT] |=> active_profile == 2'h0) // [RULE4]
    else $error("profile not forced to zero while switching disabled");
  a_select_pin_one: assert property (timer_ctrl[freq_ctrl_pkg::SWITCH_EN_BIT] && !timeout_flag && // [RULE4]
    pin1_fn == freq_ctrl_pkg::FN_SWITCH && pin3_fn != freq_ctrl_pkg::FN_SWITCH |=> active_profile == {1'b0, $past(pin1)})
    else $error("single pin selection wrong");
  a_flag_on_expire: assert property (expire |=> timeout_flag) // [RULE12]
    else $error("timeout flag not set on expiry");
  a_flag_cleared: assert property (!timer_ctrl[freq_ctrl_pkg::TIMER_EN_BIT] && !expire |=> !timeout_flag) // [RULE12]
    else $error("timeout flag not cleared");
  a_reset_pulse_start: assert property (s_expire_armed |=> s_pulse_started ##1 pulse_active) // [RULE13]
    else $error("reset pulse not started at expiry");
  a_profile_zero: assert property (timeout_flag |=> active_profile == 2'h0) // [RULE14]
    else $error("profile not returned to zero after timeout");
  a_switch_off: assert property (pulse_last |=> !timer_ctrl[freq_ctrl_pkg::SWITCH_EN_BIT] && !pulse_active) // [RULE15]
    else $error("switching still enabled after reset pulse");
  a_power_down_stop: assert property (!power_down_n |=> !single_ended_out1_run && !diff1_run && !diff2_run) // [RULE18]
    else $error("output running during power-down");
  a_power_save: assert property (pin1_fn == freq_ctrl_pkg::FN_POWER_SAVE && !pin1 |=> out1_use_32k) // [RULE8]
    else $error("output one not moved to 32kHz");
  a_profile_store: assert property (do_write && aw_addr == freq_ctrl_pkg::PROFILE_DATA_OFS && w_strb == 4'hF // [RULE7]
    |=> profile[$past(prog_sel)] == $past(w_data[DW-1:0]))
    else $error("profile data not stored in selected slot");
endmodule
`default_nettype wire

/* pkg/freq_ctrl_pkg.sv */
// Constants and register map of the multi-function pin frequency control block
`default_nettype none
package freq_ctrl_pkg;
  localparam int CLK_KHZ = 25000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TIMER_BASE_MS = 500;
  localparam int RESET_PULSE_MS = 250;
  localparam int STEP_INTERVAL_NS = 1000;
  localparam int TIMER_BASE_CYCLES = TIMER_BASE_MS * CLK_KHZ;
  localparam int RESET_PULSE_CYCLES = RESET_PULSE_MS * CLK_KHZ;
  localparam int STEP_CYCLES = STEP_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 28;
  localparam int PROFILES = 4;
  localparam int DIV_W = 24;
  localparam logic [23:0] DIV_STEP = 24'h000100;
  localparam logic [23:0] PROFILE_RESET = 24'h400000;
  // Register byte offsets
  localparam logic [7:0] FUNC_SEL_OFS = 8'h00;
  localparam logic [7:0] TIMER_CTRL_OFS = 8'h04;
  localparam logic [7:0] OUT_CTRL_OFS = 8'h08;
  localparam logic [7:0] PROG_SEL_OFS = 8'h0C;
  localparam logic [7:0] PROFILE_DATA_OFS = 8'h10;
  localparam logic [7:0] XTAL_TRIM_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] VCO_NOW_OFS = 8'h1C;
  // Field positions
  localparam int PIN1_FS_LSB = 5;
  localparam int PIN3_FS_LSB = 2;
  localparam int SER_SEL_BIT = 4;
  localparam int REG_PROF_LSB = 0;
  localparam int SWITCH_EN_BIT = 4;
  localparam int TIMER_EN_BIT = 3;
  localparam int RST_CTRL_BIT = 2;
  localparam int TSEL_LSB = 0;
  localparam int PIN1_RST_OUT_BIT = 5;
  localparam int OE_EN_BIT = 0;
  localparam int OUT1_EN_BIT = 1;
  localparam int DIFF1_EN_BIT = 2;
  localparam int DIFF2_EN_BIT = 3;
  localparam int CLK32_EN_BIT = 4;
  localparam int PROG_LSB = 2;
  localparam int XOUT_LSB = 4;
  // Pin function codes
  localparam logic [1:0] FN_OUT_ENABLE = 2'h0;
  localparam logic [1:0] FN_POWER_DOWN = 2'h1;
  localparam logic [1:0] FN_POWER_SAVE = 2'h2;
  localparam logic [1:0] FN_SWITCH = 2'h3;
  // Reset values and AXI4-Lite response codes
  localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RESET = 8'h00;
  localparam logic [7:0] OUT_CTRL_RESET = 8'h1F;
  localparam logic [7:0] XTAL_TRIM_RESET = 8'h00;
  localparam logic [1:0] PROG_SEL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* design/pin_sync3.sv */
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync3 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  // Idle pins read high, so power-down and select inputs start inactive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ff1 <= '1;
      ff2 <= '1;
      ff3 <= '1;
      level <= '1;
    end
    else
    begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
      // Follow the pin only once two stages agree, else hold
      level <= (ff2 & ff3) | (level & (ff2 ^ ff3));
    end
  end
endmodule
`default_nettype wire

/* design/vco_step_limiter.sv */
// Steps the feedback divider toward its target in bounded increments
`default_nettype none
module vco_step_limiter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [freq_ctrl_pkg::DIV_W-1:0] target,
  output logic [freq_ctrl_pkg::DIV_W-1:0] current,
  output logic busy
);
  localparam int CW = 8;
  logic [CW-1:0] tick_count;
  logic tick;

  assign tick = (tick_count == CW'(freq_ctrl_pkg::STEP_CYCLES - 1));
  assign busy = (current != target);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      tick_count <= '0;
    else
      tick_count <= tick_count + 1'b1;
  end

  // Never jump: the loop must track each small step without overshoot [RULE2] [RULE3]
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      current <= freq_ctrl_pkg::PROFILE_RESET;
    else if (tick && busy)
    begin
      if (target > current)
        current <= (target - current > freq_ctrl_pkg::DIV_STEP) ? current + freq_ctrl_pkg::DIV_STEP : target;
      else
        current <= (current - target > freq_ctrl_pkg::DIV_STEP) ? current - freq_ctrl_pkg::DIV_STEP : target;
    end
  end

  a_step_bounded: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    (current > $past(current) ? current - $past(current) : $past(current) - current) <= freq_ctrl_pkg::DIV_STEP)
    else $error("divider moved by more than one step");
  a_step_direction: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    (tick && target > current) |=> current > $past(current))
    else $error("divider did not move toward target");
endmodule
`default_nettype wire

/* testbench/pin_partner.sv */
// End device on pin one, resolving the shared pin level
`default_nettype none
module pin_partner (
  input wire logic dev_level,
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic pin_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // Block drives the pin whenever its pin one output enable is set, else the end device does
  assign pin_wire = dut_oe ? dut_out : dev_level;
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the pin frequency control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TB = 40;
  localparam int RP = 10;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, p1, p3, scl, sda, pin_out, pin_oe, pin_wire;
  logic se1, use32, d1, d2, c32, pd;
  logic [7:0] awaddr, araddr, fs, ts, oc;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, active_profile;
  logic [23:0] vco_divider;
  logic [23:0] prof [4];
  logic [3:0] xin_trim, xout_trim;
  int errors, n_tests;
  multi_function_pin_freq_control #(.TIMER_BASE_CYCLES(TB), .RESET_PULSE_CYCLES(RP)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .control_pin_one_in(pin_wire), .control_pin_one_out(pin_out), .control_pin_one_oe(pin_oe),
    .control_pin_three(p3), .serial_clock_pin(scl), .serial_data_pin(sda),
    .vco_divider(vco_divider), .active_profile(active_profile), .single_ended_out1_run(se1),
    .out1_use_32k(use32), .diff1_run(d1), .diff2_run(d2), .clk32k_run(c32),
    .chip_power_down(pd), .xin_trim(xin_trim), .xout_trim(xout_trim)
  );
  pin_partner end_dev (.dev_level(p1), .dut_out(pin_out), .dut_oe(pin_oe), .pin_wire(pin_wire));
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic results();
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int i, input int lim);
    if (i >= lim)
    begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(i, 50);
    bready <= 1'b0;
    chk(bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(i, 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(r, er);
  endtask
  // Selection priority: disabled, one or two pins, register field, serial pins
  function automatic int sel_exp();
    if (!ts[4]) return 0;
    if (fs[6:5] == freq_ctrl_pkg::FN_SWITCH)
      return (fs[3:2] == freq_ctrl_pkg::FN_SWITCH) ? int'({p3, p1}) : int'(p1);
    if (fs[4]) return int'(fs[1:0]);
    return int'({scl, sda});
  endfunction
  function automatic logic [31:0] pwr_exp();
    logic dn, g;
    dn = fs[6:5] == freq_ctrl_pkg::FN_POWER_DOWN && !p1;
    g = oc[0] && !dn;
    return {26'h0, g && oc[1] && !(fs[6:5] == freq_ctrl_pkg::FN_OUT_ENABLE && !p1),
      fs[6:5] == freq_ctrl_pkg::FN_POWER_SAVE && !p1, g && oc[2], g && oc[3], oc[4], dn};
  endfunction
  task automatic settle(input int k);
    int i;
    logic [23:0] prev;
    for (i = 0; i < 1000 && vco_divider !== prof[k]; i++)
    begin
      prev = vco_divider;
      @(posedge aclk);
      chk(32'(vco_divider - prev <= 24'h100 || prev - vco_divider <= 24'h100), 1);
    end
    tmo(i, 1000);
    chk(active_profile, 32'(k));
    chk(vco_divider, prof[k]);
  endtask
  initial
  begin
    int i, k;
    logic [31:0] d, x;
    logic [1:0] r;
    errors = 0;
    n_tests = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, p3} = '0;
    {awaddr, araddr, wdata} = '0;
    {p1, scl, sda} = 3'h7;
    void'($urandom(42));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(freq_ctrl_pkg::OUT_CTRL_OFS, 32'h1F, freq_ctrl_pkg::RESP_OKAY);
    rchk(freq_ctrl_pkg::FUNC_SEL_OFS, 32'h0, freq_ctrl_pkg::RESP_OKAY);
    rchk(8'h22, 32'h0, freq_ctrl_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0, freq_ctrl_pkg::RESP_SLVERR);
    // Trim code for an 8 pF crystal: the load minus 7 pF, times two
    x = {24'h0, 4'($urandom), 4'((8 - 7) * 2)};
    wr(freq_ctrl_pkg::XTAL_TRIM_OFS, x, freq_ctrl_pkg::RESP_OKAY);
    rchk(freq_ctrl_pkg::XTAL_TRIM_OFS, x, freq_ctrl_pkg::RESP_OKAY);
    chk({xout_trim, xin_trim}, x);
    // Profiles kept near the reset value so stepping finishes quickly
    for (i = 0; i < 8; i++)
    begin
      k = i % 4;
      if (i < 4) prof[k] = 24'h3FF800 + 24'($urandom_range(0, 4095));
      wr(freq_ctrl_pkg::PROG_SEL_OFS, 32'(k) << 2, freq_ctrl_pkg::RESP_OKAY);
      if (i < 4) wr(freq_ctrl_pkg::PROFILE_DATA_OFS, {8'h0, prof[k]}, freq_ctrl_pkg::RESP_OKAY);
      else rchk(freq_ctrl_pkg::PROFILE_DATA_OFS, {8'h0, prof[k]}, freq_ctrl_pkg::RESP_OKAY);
    end
    // Pin three never set to switching alone
    for (i = 0; i < 16; i++)
    begin
      k = i % 4;
      ts = (i < 12) ? 8'h10 : 8'h00;
      fs = (i < 4 || i >= 12) ? 8'h10 | 8'(k) : (i < 8) ? 8'h00 : (i < 10) ? 8'h60 : 8'h6C;
      wr(freq_ctrl_pkg::TIMER_CTRL_OFS, {24'h0, ts}, freq_ctrl_pkg::RESP_OKAY);
      wr(freq_ctrl_pkg::FUNC_SEL_OFS, {24'h0, fs}, freq_ctrl_pkg::RESP_OKAY);
      scl <= k[1];
      sda <= k[0];
      p1 <= k[0];
      p3 <= (i >= 10 && i < 12) ? k[1] : 1'($urandom);
      repeat (8) @(posedge aclk);
      settle(sel_exp());
    end
    ts = 8'h00;
    wr(freq_ctrl_pkg::TIMER_CTRL_OFS, 32'h0, freq_ctrl_pkg::RESP_OKAY);
    for (i = 0; i < 12; i++)
    begin
      fs = 8'(i % 3) << 5;
      oc = (i < 6) ? 8'h1F : 8'($urandom_range(0, 31));
      wr(freq_ctrl_pkg::FUNC_SEL_OFS, {24'h0, fs}, freq_ctrl_pkg::RESP_OKAY);
      wr(freq_ctrl_pkg::OUT_CTRL_OFS, {24'h0, oc}, freq_ctrl_pkg::RESP_OKAY);
      p1 <= 1'((i / 3) % 2);
      repeat (8) @(posedge aclk);
      chk({26'h0, se1, use32, d1, d2, c32, pd}, pwr_exp());
    end
    p1 <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      fs = 8'h13;
      ts = 8'h3C | 8'(i);
      wr(freq_ctrl_pkg::FUNC_SEL_OFS, {24'h0, fs}, freq_ctrl_pkg::RESP_OKAY);
      wr(freq_ctrl_pkg::TIMER_CTRL_OFS, {24'h0, ts}, freq_ctrl_pkg::RESP_OKAY);
      for (k = 0; k < 400 && pin_wire; k++) @(posedge aclk);
      chk(32'(k >= (TB << i) - 4 && k <= (TB << i) + 4), 1);
      for (k = 0; k < RP + 5 && !pin_wire; k++) @(posedge aclk);
      chk(k, RP);
      chk(pin_oe, 1);
      repeat (2) @(posedge aclk);
      chk(active_profile, 0);
      rchk(freq_ctrl_pkg::TIMER_CTRL_OFS, {24'h0, ts & 8'hEF}, freq_ctrl_pkg::RESP_OKAY);
      rd(freq_ctrl_pkg::STATUS_OFS, d, r);
      chk(d[0], 1);
      wr(freq_ctrl_pkg::TIMER_CTRL_OFS, 32'h0, freq_ctrl_pkg::RESP_OKAY);
      rd(freq_ctrl_pkg::STATUS_OFS, d, r);
      chk(d[0], 0);
    end
    results();
  end
endmodule
`default_nettype wire
